/* design/ivam_pkg.sv */
// Constants and carrier types for the interrupt vector address map.
// Notes on behaviour
// - Every reset cause fetches from the one reset vector, which is address zero when nothing relocates it.
// - There are 31 vectors of two words each, vector n sitting at offset 2*(n-1), the last at 0x003C.
// - External requests 0, 1 and 2 use offsets 0x0002, 0x0004 and 0x0006.
// - Pin-change requests 0 to 3 use the consecutive offsets 0x0008 to 0x000E.
// - Watchdog time-out uses 0x0010 and timer 2 match A, match B and overflow use 0x0012 to 0x0016.
// - Timer 1 capture, match A, match B and overflow use 0x0018, 0x001A, 0x001C and 0x001E.
// - Timer 0 match A, match B and overflow use 0x0020, 0x0022 and 0x0024.
// - SPI done uses 0x0026 and serial port 0 receive, data-empty and transmit use 0x0028 to 0x002C.
// - Comparator, ADC, EEPROM, two-wire and program-store requests use 0x002E to 0x0036.
// - Serial port 1 receive, data-empty and transmit use 0x0038, 0x003A and 0x003C.
// - With the table select bit set each interrupt vector is the boot section start plus its offset, else the offset.
// - A programmed boot reset fuse makes reset fetch the boot reset address, else zero, independent of select.
// - Fuse value 1 means unprogrammed and 0 programmed; vectors start at base plus 0x0002.
// - Change enable clears itself four cycles after it is set or when select is written, and blocks interrupts.
package ivam_pkg;
   localparam int ADDR_W = 17;
   localparam int NUM_SRC = 30;
   localparam int NUM_W = 5;
   localparam logic [16:0] RESET_VEC_ADDR = 17'h00000;
   localparam logic [16:0] BOOT_RESET_ADDR_DEF = 17'h1F000;
   localparam logic [NUM_W-1:0] FIRST_IRQ_VEC_NUM = 5'h02;
   localparam logic [NUM_W-1:0] LAST_VEC_NUM = 5'h1F;
   localparam logic [6:0] LAST_VEC_OFFSET = 7'h3C;
   localparam logic FUSE_PROGRAMMED = 1'h0;
   localparam logic [2:0] CHANGE_WINDOW_CYC = 3'h4;
   localparam logic [2:0] CHANGE_WINDOW_RESET = 3'h0;
   // Table offset of each request line, index 0 being vector number 2.
   localparam logic [NUM_SRC-1:0][6:0] VEC_OFFSET = '{
      7'h3C, 7'h3A, 7'h38,
      7'h36, 7'h34, 7'h32, 7'h30, 7'h2E,
      7'h2C, 7'h2A, 7'h28, 7'h26,
      7'h24, 7'h22, 7'h20,
      7'h1E, 7'h1C, 7'h1A, 7'h18,
      7'h16, 7'h14, 7'h12, 7'h10,
      7'h0E, 7'h0C, 7'h0A, 7'h08,
      7'h06, 7'h04, 7'h02
   };
   // Write data of the mcu_control_reg bits that this block owns.
   typedef struct packed {
      logic vector_table_select;
      logic vector_change_enable;
   } ivam_ctrl_t;
   // Vector handed to the core's program counter load.
   typedef struct packed {
      logic valid;
      logic [NUM_W-1:0] num;
      logic [ADDR_W-1:0] addr;
   } ivam_vec_t;
endpackage : ivam_pkg

/* design/ivam_prio.sv */
// Fixed priority picker: lowest request index wins.
`timescale 1ns/1ps
`default_nettype none
module ivam_prio (
   // Requests
   input wire logic [ivam_pkg::NUM_SRC-1:0] req_i,
   // Winner
   output logic any_o,
   output logic [ivam_pkg::NUM_W-1:0] idx_o
);
   always_comb begin
      any_o = 1'b0;
      idx_o = '0;
      for (int i = ivam_pkg::NUM_SRC - 1; i >= 0; i--) begin
         if (req_i[i]) begin
            any_o = 1'b1;
            idx_o = ivam_pkg::NUM_W'(i);
         end
      end
   end
endmodule : ivam_prio
`default_nettype wire

/* design/ivam_top.sv */
// Reset and interrupt vector address generation with relocatable table.
`timescale 1ns/1ps
`default_nettype none
module ivam_top #(
   parameter logic [16:0] BOOT_RESET_ADDR = ivam_pkg::BOOT_RESET_ADDR_DEF
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Fuse pin
   input wire logic boot_reset_fuse_i,
   // Peripheral requests, same clock
   input wire logic [ivam_pkg::NUM_SRC-1:0] irq_i,
   // Core side
   input wire logic ctrl_wr_i,
   input wire ivam_pkg::ivam_ctrl_t ctrl_wdata_i,
   input wire logic instr_retire_i,
   // Outputs
   output ivam_pkg::ivam_vec_t vec_o,
   output logic [ivam_pkg::ADDR_W-1:0] reset_addr_o,
   output ivam_pkg::ivam_ctrl_t ctrl_o,
   output logic irq_blocked_o
);
   // ***************************************************************
   // Fuse capture
   // ***************************************************************
   logic fuse_meta;
   logic fuse_sync;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fuse_meta <= 1'b1;
         fuse_sync <= 1'b1;
      end else begin
         fuse_meta <= boot_reset_fuse_i;
         fuse_sync <= fuse_meta;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         reset_addr_o <= ivam_pkg::RESET_VEC_ADDR;
      end else if (fuse_sync == ivam_pkg::FUSE_PROGRAMMED) begin
         reset_addr_o <= BOOT_RESET_ADDR;
      end else begin
         reset_addr_o <= ivam_pkg::RESET_VEC_ADDR;
      end
   end

   // ***************************************************************
   // Timed change of the table select bit
   // ***************************************************************
   logic [2:0] window_cnt;
   logic post_write_block;
   logic vce_write;
   logic vsel_write;
   assign vce_write = ctrl_wr_i && ctrl_wdata_i.vector_change_enable;
   assign vsel_write = ctrl_wr_i && !ctrl_wdata_i.vector_change_enable && ctrl_o.vector_change_enable;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl_o.vector_change_enable <= 1'b0;
         window_cnt <= ivam_pkg::CHANGE_WINDOW_RESET;
      end else if (vce_write) begin
         ctrl_o.vector_change_enable <= 1'b1;
         window_cnt <= ivam_pkg::CHANGE_WINDOW_CYC;
      end else if (vsel_write || window_cnt == 3'h1) begin
         ctrl_o.vector_change_enable <= 1'b0;
         window_cnt <= ivam_pkg::CHANGE_WINDOW_RESET;
      end else if (window_cnt != ivam_pkg::CHANGE_WINDOW_RESET) begin
         window_cnt <= window_cnt - 3'h1;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl_o.vector_table_select <= 1'b0;
      end else if (vsel_write) begin
         ctrl_o.vector_table_select <= ctrl_wdata_i.vector_table_select;
      end
   end

   // Blocking lasts until the instruction after the select write retires.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         post_write_block <= 1'b0;
      end else if (vsel_write) begin
         post_write_block <= 1'b1;
      end else if (instr_retire_i) begin
         post_write_block <= 1'b0;
      end
   end

   logic block_now;
   assign block_now = ctrl_o.vector_change_enable || post_write_block || vce_write;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_blocked_o <= 1'b0;
      end else begin
         irq_blocked_o <= block_now;
      end
   end

   // ***************************************************************
   // Vector selection
   // ***************************************************************
   logic win_any;
   logic [ivam_pkg::NUM_W-1:0] win_idx;
   logic [ivam_pkg::ADDR_W-1:0] table_base;

   ivam_prio u_prio (
      .req_i(irq_i),
      .any_o(win_any),
      .idx_o(win_idx)
   );

   assign table_base = ctrl_o.vector_table_select ? BOOT_RESET_ADDR : ivam_pkg::RESET_VEC_ADDR;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         vec_o <= '0;
      end else begin
         vec_o.valid <= win_any && !block_now;
         vec_o.num <= win_idx + ivam_pkg::FIRST_IRQ_VEC_NUM;
         vec_o.addr <= table_base + ivam_pkg::ADDR_W'(ivam_pkg::VEC_OFFSET[win_idx]);
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   sequence s_vce_set;
      vce_write ##1 ctrl_o.vector_change_enable;
   endsequence
   sequence s_quiet4;
      !ctrl_wr_i [*4];
   endsequence

   AST_RESET_ZERO: assert property (fuse_sync && $past(fuse_sync) |=> reset_addr_o == 17'h00000)
      else $error("Reset address not zero with fuse unprogrammed.");
   AST_RESET_BOOT: assert property (!fuse_sync |=> reset_addr_o == BOOT_RESET_ADDR)
      else $error("Reset address not boot address with fuse programmed.");
   AST_FUSE_LEVEL: assert property ($fell(fuse_sync) |=> reset_addr_o != 17'h00000)
      else $error("Fuse value zero not taken as programmed.");
   AST_VEC_FORMULA: assert property (vec_o.valid |-> vec_o.addr - $past(table_base) == ivam_pkg::ADDR_W'({vec_o.num, 1'b0} - 6'h2))
      else $error("Vector offset is not twice number minus one.");
   AST_VEC_RANGE: assert property (vec_o.valid |-> vec_o.num >= 5'h02 && vec_o.num <= 5'h1F)
      else $error("Vector number out of range.");
   AST_EXT0: assert property (irq_i[0] && !block_now && !ctrl_o.vector_table_select |=> vec_o.valid && vec_o.addr == 17'h00002)
      else $error("External request 0 not at its offset.");
   AST_LAST: assert property (irq_i == 30'h20000000 && !block_now && !ctrl_o.vector_table_select |=> vec_o.addr == 17'h0003C)
      else $error("Last vector not at its offset.");
   AST_RELOC: assert property (irq_i[0] && !block_now && ctrl_o.vector_table_select |=> vec_o.addr == BOOT_RESET_ADDR + 17'h2)
      else $error("Relocated vector address wrong.");
   AST_LOWEST: assert property (vec_o.valid |-> ($past(irq_i) & ((30'h1 << (vec_o.num - 5'h2)) - 30'h1)) == 30'h0)
      else $error("A lower pending request was passed over.");
   AST_VCE_TIMEOUT: assert property (s_vce_set ##0 s_quiet4 |=> !ctrl_o.vector_change_enable)
      else $error("Change enable outlived its four cycles.");
   AST_VCE_BLOCKS: assert property (ctrl_o.vector_change_enable |=> !vec_o.valid)
      else $error("Interrupt issued while change enable set.");
   AST_SEL_GUARD: assert property ($changed(ctrl_o.vector_table_select) |-> $past(ctrl_o.vector_change_enable))
      else $error("Table select changed without change enable.");

   // ***************************************************************
   // Blocking and window checks
   // ***************************************************************
   // Counts the cycles that change enable has stood since it was last set.
   // The count lets the check below bound the window without a long repetition.
   logic [2:0] vce_age;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         vce_age <= 3'h0;
      end else if (vce_write) begin
         vce_age <= 3'h1;
      end else if (ctrl_o.vector_change_enable) begin
         vce_age <= vce_age + 3'h1;
      end else begin
         vce_age <= 3'h0;
      end
   end

   // Change enable never stands longer than its window.
   AST_VCE_AGE: assert property (ctrl_o.vector_change_enable |-> vce_age <= 3'h4)
      else $error("Change enable stood longer than four cycles.");
   AST_VCE_WINDOW: assert property (ctrl_o.vector_change_enable |-> window_cnt != 3'h0)
      else $error("Change enable set with an empty window.");
   AST_WINDOW_BOUND: assert property (window_cnt <= ivam_pkg::CHANGE_WINDOW_CYC)
      else $error("Window count above its load value.");
   // The write cycle itself must already hold back any vector.
   AST_VCE_WRITE_BLOCKS: assert property (vce_write |=> !vec_o.valid)
      else $error("Interrupt issued in the change enable write cycle.");
   AST_SEL_WRITE: assert property (vsel_write |=> !ctrl_o.vector_change_enable && post_write_block)
      else $error("Select write did not clear change enable and start blocking.");
   AST_SEL_HOLD: assert property (!vsel_write |=> $stable(ctrl_o.vector_table_select))
      else $error("Table select moved without a select write.");
   AST_RETIRE_ENDS: assert property (post_write_block && instr_retire_i && !vsel_write |=> !post_write_block)
      else $error("Blocking outlived the retire after the select write.");
   // The flag reports the internal block one cycle late.
   AST_FLAG_ON: assert property (block_now |=> irq_blocked_o)
      else $error("Blocked flag low while blocking.");
   AST_FLAG_OFF: assert property (!block_now |=> !irq_blocked_o)
      else $error("Blocked flag high while not blocking.");
   AST_IDLE: assert property (irq_i == 30'h0 |=> !vec_o.valid)
      else $error("Vector issued with no request pending.");
   AST_BASE_ZERO: assert property (vec_o.valid && !$past(ctrl_o.vector_table_select) |-> vec_o.addr <= 17'h0003C)
      else $error("Unrelocated vector beyond the last table slot.");
endmodule : ivam_top
`default_nettype wire

/* sim/ivam_core_model.sv */
// Core-side model: retires instructions on command and latches fetched vectors.
`timescale 1ns/1ps
`default_nettype none
module ivam_core_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Command and vector
   input wire logic retire_req_i,
   input wire ivam_pkg::ivam_vec_t vec_i,
   // Core state
   output logic instr_retire_o,
   output logic [ivam_pkg::ADDR_W-1:0] fetch_addr_o
);
   // Retire arrives one cycle after it is requested, like a real pipeline.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         instr_retire_o <= 1'h0;
      end else begin
         instr_retire_o <= retire_req_i;
      end
   end
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fetch_addr_o <= '0;
      end else if (vec_i.valid) begin
         fetch_addr_o <= vec_i.addr;
      end
   end
endmodule : ivam_core_model
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench for the interrupt vector address map.
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [16:0] BOOT = 17'h0E000;
   logic clk, arst_n, fuse, ctrl_wr, retire, retire_req, blocked;
   logic [29:0] irq;
   logic [16:0] reset_addr, fetch_addr;
   ivam_pkg::ivam_ctrl_t ctrl_wdata, ctrl;
   ivam_pkg::ivam_vec_t vec;
   int n_errors = 0;
   int n_compared = 0;
   ivam_top #(.BOOT_RESET_ADDR(BOOT)) ivam_top_i (.clk_i(clk), .arst_n_i(arst_n), .boot_reset_fuse_i(fuse),
      .irq_i(irq), .ctrl_wr_i(ctrl_wr), .ctrl_wdata_i(ctrl_wdata), .instr_retire_i(retire), .vec_o(vec),
      .reset_addr_o(reset_addr), .ctrl_o(ctrl), .irq_blocked_o(blocked));
   ivam_core_model ivam_core_model_i (.clk_i(clk), .arst_n_i(arst_n), .retire_req_i(retire_req),
      .vec_i(vec), .instr_retire_o(retire), .fetch_addr_o(fetch_addr));
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   task automatic wr(input logic sel, input logic en);
      ctrl_wr = 1'h1;
      ctrl_wdata = {sel, en};
      cyc(1);
      ctrl_wr = 1'h0;
   endtask : wr
   task automatic close_out;
      if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : close_out
   task automatic t_reset_addr;
      chk("reset addr", 32'(reset_addr), 32'h0);
      fuse = 1'h0;
      cyc(4);
      chk("boot reset addr", 32'(reset_addr), 32'(BOOT));
      fuse = 1'h1;
      cyc(4);
      chk("reset addr unprog", 32'(reset_addr), 32'h0);
   endtask : t_reset_addr
   task automatic t_table;
      for (int i = 0; i < 30; i++) begin
         irq = 30'h1 << i;
         cyc(2);
         chk("valid", 32'(vec.valid), 32'h1);
         chk("num", 32'(vec.num), 32'(i + 2));
         chk("addr", 32'(vec.addr), 32'(2 * (i + 1)));
      end
      irq = 30'h0;
      cyc(2);
      chk("idle valid", 32'(vec.valid), 32'h0);
   endtask : t_table
   task automatic t_prio;
      irq = 30'h20000140;
      cyc(2);
      chk("prio addr", 32'(vec.addr), 32'h0000000E);
      irq = 30'h3FFFFFFF;
      cyc(2);
      chk("prio num", 32'(vec.num), 32'h2);
      irq = 30'h0;
   endtask : t_prio
   task automatic t_reloc(input logic sel);
      irq = 30'h10;
      wr(1'h0, 1'h1);
      chk("enable set", 32'(ctrl.vector_change_enable), 32'h1);
      chk("blocked flag", 32'(blocked), 32'h1);
      cyc(1);
      chk("blocked", 32'(vec.valid), 32'h0);
      wr(sel, 1'h0);
      chk("select", 32'(ctrl), 32'({sel, 1'h0}));
      cyc(3);
      chk("still blocked", 32'(vec.valid), 32'h0);
      chk("blocked flag held", 32'(blocked), 32'h1);
      retire_req = 1'h1;
      cyc(1);
      retire_req = 1'h0;
      cyc(3);
      chk("reloc valid", 32'(vec.valid), 32'h1);
      chk("blocked flag clear", 32'(blocked), 32'h0);
      chk("reloc addr", 32'(fetch_addr), 32'((sel ? BOOT : 17'h0) + 17'h0000A));
      chk("reset indep", 32'(reset_addr), 32'h0);
      irq = 30'h0;
      cyc(1);
   endtask : t_reloc
   task automatic t_timeout;
      wr(1'h0, 1'h1);
      cyc(3);
      chk("enable held", 32'(ctrl.vector_change_enable), 32'h1);
      cyc(1);
      chk("enable clear", 32'(ctrl.vector_change_enable), 32'h0);
      wr(1'h1, 1'h0);
      chk("late select", 32'(ctrl.vector_table_select), 32'h0);
      irq = 30'h1;
      cyc(3);
      chk("vec start", 32'(vec.addr), 32'h2);
      irq = 30'h0;
   endtask : t_timeout
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   initial begin
      #40000;
      n_errors++;
      close_out();
   end
   initial begin
      {arst_n, ctrl_wr, retire_req, irq, ctrl_wdata} = '0;
      fuse = 1'h1;
      repeat (12) @(posedge clk);
      @(negedge clk);
      chk("reset ctrl", 32'(ctrl), 32'h0);
      arst_n = 1'h1;
      cyc(4);
      t_reset_addr();
      t_table();
      t_prio();
      t_reloc(1'h1);
      t_reloc(1'h0);
      t_timeout();
      close_out();
   end
endmodule : tb
`default_nettype wire
